// >>> hdl/msd_pkg.sv
package msd_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int PROG_AW = 24;
  localparam int PC_W = 23;
  localparam int DATA_AW = 16;
  localparam int DATA_W = 16;
  localparam int NEAR_AW = 13;
  localparam int PAGE_W = 8;
  localparam int WREG_IDX_W = 4;

  // ****************************************************************
  // program space map
  // ****************************************************************
  localparam logic [PROG_AW-1:0] PROG_RESET_ADDR = 24'h000000;
  localparam logic [PROG_AW-1:0] PROG_RESET_TARGET = 24'h000002;
  localparam logic [PROG_AW-1:0] PROG_IVT_START = 24'h000004;
  localparam logic [PROG_AW-1:0] PROG_IVT_END = 24'h0000ff;
  localparam logic [PROG_AW-1:0] PROG_AIVT_START = 24'h000100;
  localparam logic [PROG_AW-1:0] PROG_AIVT_END = 24'h0001ff;
  localparam logic [PROG_AW-1:0] PROG_USER_START = 24'h000200;
  localparam logic [PROG_AW-1:0] PROG_USER_LIMIT = 24'h7fffff;
  localparam logic [PROG_AW-1:0] PC_STEP = 24'h000002;
  localparam int TBL_CFG_BIT = 7;
  localparam int PSV_OFS_W = 15;

  // ****************************************************************
  // data space map
  // ****************************************************************
  localparam logic [DATA_AW-1:0] SFR_END = 16'h07ff;
  localparam logic [DATA_AW-1:0] NEAR_END = 16'h1fff;
  localparam logic [DATA_AW-1:0] STEP_BYTE = 16'h0001;
  localparam logic [DATA_AW-1:0] STEP_WORD = 16'h0002;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONES_BYTE = 8'hff;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MSD_REGION_SFR = 2'b00,
    MSD_REGION_RAM = 2'b01,
    MSD_REGION_PSV = 2'b11,
    MSD_REGION_NONE = 2'b10
  } msd_region_t;

  typedef enum logic [1:0] {
    MSD_EXT_NONE = 2'b00,
    MSD_EXT_SIGN = 2'b01,
    MSD_EXT_ZERO = 2'b11
  } msd_ext_t;

  typedef struct packed {
    logic valid;
    logic is_byte;
    logic [DATA_AW-1:0] addr;
  } msd_rd_req_t;

  typedef struct packed {
    logic valid;
    logic is_byte;
    logic [DATA_AW-1:0] addr;
    logic [DATA_W-1:0] data;
  } msd_wr_req_t;

  typedef struct packed {
    logic valid;
    logic table_op;
    logic [PAGE_W-1:0] table_page_pointer;
    logic [DATA_W-1:0] offset;
  } msd_tbl_req_t;

endpackage : msd_pkg

// >>> hdl/msd_agu.sv
`timescale 1ns/1ps
`default_nettype none
// one data address path: decode, lane select, misalign check, post-inc
module msd_agu
  import msd_pkg::*;
#(
  parameter int RAM_BYTES = 30720
)
(
  // request
  input wire msd_pkg::msd_rd_req_t req,
  // decode
  output var msd_pkg::msd_region_t region,
  output logic implemented,
  output logic misaligned,
  output logic [1:0] lane_strobe,
  output logic [DATA_AW-1:0] post_inc_addr
);
  import msd_pkg::*;

  localparam logic [DATA_AW-1:0] RAM_END = DATA_AW'(RAM_BYTES - 1);

  always_comb
  begin
    if (req.addr[DATA_AW-1])
      region = MSD_REGION_PSV;
    else if (req.addr <= SFR_END)
      region = MSD_REGION_SFR;
    else if (req.addr <= RAM_END)
      region = MSD_REGION_RAM;
    else
      region = MSD_REGION_NONE;
  end

  assign implemented = (region != MSD_REGION_NONE);
  assign misaligned = req.valid & ~req.is_byte & req.addr[0];
  // low lane is the even byte
  assign lane_strobe = req.is_byte ? {req.addr[0], ~req.addr[0]} : 2'b11;
  assign post_inc_addr = req.addr + (req.is_byte ? STEP_BYTE : STEP_WORD);

endmodule : msd_agu
`default_nettype wire

// >>> hdl/msd_memory_space_address_decode.sv
`timescale 1ns/1ps
`default_nettype none
module msd_memory_space_address_decode
  import msd_pkg::*;
#(
  parameter int RAM_BYTES = 30720
)
(
  // system
  input wire logic clk,
  input wire logic reset,
  // program counter control
  input wire logic pc_advance,
  input wire logic pc_retreat,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  // table and visibility requests
  input wire msd_pkg::msd_tbl_req_t tbl_req,
  input wire logic [PAGE_W-1:0] visibility_page_reg,
  input wire logic psv_enable,
  // data read and write requests
  input wire msd_pkg::msd_rd_req_t rd_req,
  input wire msd_pkg::msd_wr_req_t wr_req,
  input wire logic near_direct,
  input wire logic [NEAR_AW-1:0] near_field,
  // memory side
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic sfr_hit,
  // working register update
  input wire logic wreg_wr,
  input wire logic [WREG_IDX_W-1:0] wreg_idx,
  input wire logic wreg_byte,
  input wire logic [DATA_W-1:0] wreg_data,
  input wire msd_pkg::msd_ext_t ext_op,
  // program side outputs
  output logic [PROG_AW-1:0] prog_addr,
  output logic prog_upper_word,
  output logic prog_access_ok,
  output logic prog_in_vectors,
  // data side outputs
  output logic [DATA_AW-1:0] rd_word_addr,
  output logic [DATA_AW-1:0] wr_word_addr,
  output logic [1:0] wr_lane_strobe,
  output logic [DATA_W-1:0] wr_data_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic [DATA_AW-1:0] rd_next_addr,
  output logic [DATA_AW-1:0] wr_next_addr,
  // exceptions
  output logic addr_error_pulse,
  output logic addr_error_is_write,
  // register file view
  output logic [DATA_W-1:0] wreg_out [16]
);
  import msd_pkg::*;

  // ****************************************************************
  // program counter
  // ****************************************************************
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;

  always_comb
  begin
    pc_next = pc_reg;
    if (pc_load)
      pc_next = {pc_load_value[PC_W-1:1], 1'b0};
    else if (pc_advance)
      pc_next = pc_reg + PC_W'(PC_STEP);
    else if (pc_retreat)
      pc_next = pc_reg - PC_W'(PC_STEP);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      pc_reg <= PC_W'(PROG_RESET_ADDR);
    else
      pc_reg <= pc_next;
  end

  // ****************************************************************
  // program address formation
  // ****************************************************************
  logic [PROG_AW-1:0] prog_addr_next;
  logic prog_ok_next;

  always_comb
  begin
    if (tbl_req.valid && tbl_req.table_op)
    begin
      // table page forms the top byte
      prog_addr_next = {tbl_req.table_page_pointer, tbl_req.offset};
      // top page bit opens configuration space
      prog_ok_next = !prog_addr_next[PROG_AW-1] ||
                     tbl_req.table_page_pointer[TBL_CFG_BIT];
    end
    else if (tbl_req.valid && psv_enable && rd_req.addr[DATA_AW-1])
    begin
      prog_addr_next = {1'b0, visibility_page_reg, rd_req.addr[PSV_OFS_W-1:0]};
      prog_ok_next = 1'b1;
    end
    else
    begin
      prog_addr_next = {1'b0, pc_reg};
      prog_ok_next = !prog_addr_next[PROG_AW-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prog_addr <= PROG_RESET_ADDR;
      prog_upper_word <= 1'b0;
      prog_access_ok <= 1'b1;
      prog_in_vectors <= 1'b1;
    end
    else
    begin
      prog_addr <= prog_addr_next;
      prog_upper_word <= prog_addr_next[0];
      prog_access_ok <= prog_ok_next && (prog_addr_next <= PROG_USER_LIMIT
                        || tbl_req.table_page_pointer[TBL_CFG_BIT]);
      prog_in_vectors <= prog_addr_next < PROG_USER_START;
    end
  end

  // ****************************************************************
  // data address generation, one path per direction
  // ****************************************************************
  msd_rd_req_t rd_eff;
  msd_rd_req_t wr_as_rd;
  msd_region_t rd_region;
  msd_region_t wr_region;
  logic rd_impl;
  logic wr_impl;
  logic rd_mis;
  logic wr_mis;
  logic [1:0] rd_lanes;
  logic [1:0] wr_lanes;
  logic [DATA_AW-1:0] rd_inc;
  logic [DATA_AW-1:0] wr_inc;

  always_comb
  begin
    rd_eff = rd_req;
    if (near_direct)
      rd_eff.addr = {{(DATA_AW-NEAR_AW){1'b0}}, near_field};
  end

  assign wr_as_rd = '{valid: wr_req.valid, is_byte: wr_req.is_byte, addr: wr_req.addr};

  msd_agu #(.RAM_BYTES(RAM_BYTES)) u_rd_agu (
    .req(rd_eff),
    .region(rd_region),
    .implemented(rd_impl),
    .misaligned(rd_mis),
    .lane_strobe(rd_lanes),
    .post_inc_addr(rd_inc)
  );

  msd_agu #(.RAM_BYTES(RAM_BYTES)) u_wr_agu (
    .req(wr_as_rd),
    .region(wr_region),
    .implemented(wr_impl),
    .misaligned(wr_mis),
    .lane_strobe(wr_lanes),
    .post_inc_addr(wr_inc)
  );

  // ****************************************************************
  // data path registers
  // ****************************************************************
  logic rd_pend_reg;
  logic rd_byte_reg;
  logic rd_hi_reg;
  logic rd_zero_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_word_addr <= ZERO_WORD;
      wr_word_addr <= ZERO_WORD;
      wr_lane_strobe <= 2'b00;
      wr_data_out <= ZERO_WORD;
      rd_next_addr <= ZERO_WORD;
      wr_next_addr <= ZERO_WORD;
      rd_pend_reg <= 1'b0;
      rd_byte_reg <= 1'b0;
      rd_hi_reg <= 1'b0;
      rd_zero_reg <= 1'b0;
    end
    else
    begin
      rd_word_addr <= {rd_eff.addr[DATA_AW-1:1], 1'b0};
      wr_word_addr <= {wr_req.addr[DATA_AW-1:1], 1'b0};
      // misaligned write runs but does not store
      wr_lane_strobe <= (wr_req.valid && !wr_mis && wr_impl) ? wr_lanes : 2'b00;
      // byte data is steered onto the lane it is written to
      wr_data_out <= (wr_req.is_byte && wr_req.addr[0]) ?
                     {wr_req.data[7:0], wr_req.data[7:0]} : wr_req.data;
      rd_next_addr <= rd_req.valid ? rd_inc : rd_next_addr;
      wr_next_addr <= wr_req.valid ? wr_inc : wr_next_addr;
      rd_pend_reg <= rd_eff.valid;
      rd_byte_reg <= rd_eff.is_byte;
      rd_hi_reg <= rd_lanes[1] & rd_eff.is_byte;
      // unused registers and holes read zero
      rd_zero_reg <= !rd_impl || (rd_region == MSD_REGION_SFR);
    end
  end

  // sfr_hit arrives with the data, one cycle after the address
  always_ff @(posedge clk)
  begin
    if (reset)
      rd_data_out <= ZERO_WORD;
    else if (rd_pend_reg)
    begin
      if (rd_zero_reg && !(sfr_hit && rd_zero_reg && rd_word_addr <= SFR_END))
        rd_data_out <= ZERO_WORD;
      else if (rd_byte_reg)
        rd_data_out <= {ZERO_BYTE, rd_hi_reg ? mem_rdata[15:8] : mem_rdata[7:0]};
      else
        rd_data_out <= mem_rdata;
    end
  end

  // ****************************************************************
  // address error
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      addr_error_pulse <= 1'b0;
      addr_error_is_write <= 1'b0;
    end
    else
    begin
      addr_error_pulse <= rd_mis | wr_mis;
      if (rd_mis | wr_mis)
        addr_error_is_write <= wr_mis;
    end
  end

  // ****************************************************************
  // working registers
  // ****************************************************************
  logic [DATA_W-1:0] wreg_reg [16];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < 16; i++)
        wreg_reg[i] <= ZERO_WORD;
    end
    else if (wreg_wr)
    begin
      case (ext_op)
        MSD_EXT_SIGN:
          wreg_reg[wreg_idx] <= {{8{wreg_data[7]}}, wreg_data[7:0]};
        MSD_EXT_ZERO:
          wreg_reg[wreg_idx] <= {ZERO_BYTE, wreg_data[7:0]};
        default:
          if (wreg_byte)
            wreg_reg[wreg_idx][7:0] <= wreg_data[7:0];
          else
            wreg_reg[wreg_idx] <= wreg_data;
      endcase
    end
  end

  assign wreg_out = wreg_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_PC_ALIGNED: assert property (@(posedge clk) disable iff (reset)
    pc_reg[0] == 1'b0) else $error("pc odd");
  AST_PC_STEP: assert property (@(posedge clk) disable iff (reset)
    (pc_advance && !pc_load) |=> pc_reg == $past(pc_reg) + 23'h2)
    else $error("pc step wrong");
  // look only at the first edge after release, where pc_reg is settled
  AST_RESET_PC: assert property (@(posedge clk)
    ($past(reset) && !reset) |-> pc_reg == 23'h0) else $error("pc not zero after reset");
  AST_MISALIGN_PULSE: assert property (@(posedge clk) disable iff (reset)
    (wr_req.valid && !wr_req.is_byte && wr_req.addr[0]) |=>
    addr_error_pulse && addr_error_is_write) else $error("no write error");
  AST_MISALIGN_NOWRITE: assert property (@(posedge clk) disable iff (reset)
    (wr_req.valid && !wr_req.is_byte && wr_req.addr[0]) |=> wr_lane_strobe == 2'b00)
    else $error("misaligned write stored");
  AST_BYTE_LANE: assert property (@(posedge clk) disable iff (reset)
    (wr_req.valid && wr_req.is_byte && wr_impl) |=>
    wr_lane_strobe == ($past(wr_req.addr[0]) ? 2'b10 : 2'b01))
    else $error("byte lane wrong");
  AST_PULSE_ONE: assert property (@(posedge clk) disable iff (reset)
    addr_error_pulse && !$past(rd_mis | wr_mis) |-> 1'b0)
    else $error("stray error pulse");
  AST_BYTE_KEEP: assert property (@(posedge clk) disable iff (reset)
    (wreg_wr && wreg_byte && ext_op == MSD_EXT_NONE) |=>
    wreg_reg[$past(wreg_idx)][15:8] == $past(wreg_reg[wreg_idx][15:8]))
    else $error("byte load changed high byte");
  AST_POSTINC: assert property (@(posedge clk) disable iff (reset)
    rd_req.valid |=> rd_next_addr == ($past(near_direct) ?
    {{(DATA_AW-NEAR_AW){1'b0}}, $past(near_field)} : $past(rd_req.addr)) +
    ($past(rd_req.is_byte) ? 16'h1 : 16'h2))
    else $error("post increment wrong");

endmodule : msd_memory_space_address_decode
`default_nettype wire

// >>> test/msd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module msd_mem_model
(
  // clock
  input wire logic clk,
  // decoder side
  input wire logic [msd_pkg::DATA_AW-1:0] rd_word_addr,
  input wire logic [msd_pkg::DATA_AW-1:0] wr_word_addr,
  input wire logic [1:0] wr_lane_strobe,
  input wire logic [msd_pkg::DATA_W-1:0] wr_data_out,
  // answer
  output logic [msd_pkg::DATA_W-1:0] mem_rdata,
  output logic sfr_hit
);
  import msd_pkg::*;
  logic [DATA_W-1:0] mem_reg [64];
  // only bits 6:1 index the array, so scenarios keep their addresses apart
  initial
  begin
    for (int i = 0; i < 64; i++) mem_reg[i] = 16'h1000 + 16'(i);
  end
  always @(posedge clk)
  begin
    if (wr_lane_strobe[0]) mem_reg[wr_word_addr[6:1]][7:0] <= wr_data_out[7:0];
    if (wr_lane_strobe[1]) mem_reg[wr_word_addr[6:1]][15:8] <= wr_data_out[15:8];
  end
  // raw word is always offered; the decoder has to zero misses itself
  assign mem_rdata = mem_reg[rd_word_addr[6:1]];
  assign sfr_hit = (rd_word_addr < 16'h0040);
endmodule : msd_mem_model
`default_nettype wire

// >>> test/msd_memory_space_address_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module msd_memory_space_address_decode_tb;
  import msd_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pc_advance = 0, pc_retreat = 0, pc_load = 0, psv_enable = 0, near_direct = 0;
  logic wreg_wr = 0, wreg_byte = 0, sfr_hit, prog_upper_word, prog_access_ok;
  logic prog_in_vectors, addr_error_pulse, addr_error_is_write;
  logic [PC_W-1:0] pc_load_value = '0;
  logic [PAGE_W-1:0] visibility_page_reg = '0;
  logic [NEAR_AW-1:0] near_field = '0;
  logic [WREG_IDX_W-1:0] wreg_idx = '0;
  logic [DATA_W-1:0] wreg_data = '0, mem_rdata, wr_data_out, rd_data_out;
  logic [PROG_AW-1:0] prog_addr;
  logic [DATA_AW-1:0] rd_word_addr, wr_word_addr, rd_next_addr, wr_next_addr;
  logic [1:0] wr_lane_strobe;
  logic [DATA_W-1:0] wreg_out [16];
  msd_tbl_req_t tbl_req = '0;
  msd_rd_req_t rd_req = '0;
  msd_wr_req_t wr_req = '0;
  msd_ext_t ext_op = MSD_EXT_NONE;
  int compares = 0;
  int miscompares = 0;

  always #5 clk = ~clk;

  msd_memory_space_address_decode i_dut (.clk(clk), .reset(reset), .pc_advance(pc_advance),
    .pc_retreat(pc_retreat), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .tbl_req(tbl_req), .visibility_page_reg(visibility_page_reg), .psv_enable(psv_enable),
    .rd_req(rd_req), .wr_req(wr_req), .near_direct(near_direct), .near_field(near_field),
    .mem_rdata(mem_rdata), .sfr_hit(sfr_hit), .wreg_wr(wreg_wr), .wreg_idx(wreg_idx),
    .wreg_byte(wreg_byte), .wreg_data(wreg_data), .ext_op(ext_op), .prog_addr(prog_addr),
    .prog_upper_word(prog_upper_word), .prog_access_ok(prog_access_ok),
    .prog_in_vectors(prog_in_vectors), .rd_word_addr(rd_word_addr),
    .wr_word_addr(wr_word_addr), .wr_lane_strobe(wr_lane_strobe), .wr_data_out(wr_data_out),
    .rd_data_out(rd_data_out), .rd_next_addr(rd_next_addr), .wr_next_addr(wr_next_addr),
    .addr_error_pulse(addr_error_pulse), .addr_error_is_write(addr_error_is_write),
    .wreg_out(wreg_out));

  msd_mem_model i_mem (.clk(clk), .rd_word_addr(rd_word_addr), .wr_word_addr(wr_word_addr),
    .wr_lane_strobe(wr_lane_strobe), .wr_data_out(wr_data_out), .mem_rdata(mem_rdata),
    .sfr_hit(sfr_hit));

  // ****************************************
  // bus cycles
  // ****************************************
  task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] exp);
    @(posedge clk);
    rd_req <= '{1'b1, b, a};
    @(posedge clk);
    rd_req <= '0;
    #1;
    `CHK(rd_word_addr, {a[15:1], 1'b0})
    `CHK(rd_next_addr, a + (b ? STEP_BYTE : STEP_WORD))
    `CHK(addr_error_pulse, ~b & a[0])
    @(posedge clk);
    #1;
    `CHK(addr_error_pulse, 1'b0)
    if (b) `CHK(rd_data_out[7:0], exp[7:0]) else if (!a[0]) `CHK(rd_data_out, exp)
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d,
                    input logic [1:0] stb);
    @(posedge clk);
    wr_req <= '{1'b1, b, a, d};
    @(posedge clk);
    wr_req <= '0;
    #1;
    `CHK(wr_lane_strobe, stb)
    `CHK(wr_word_addr, {a[15:1], 1'b0})
    `CHK(wr_next_addr, a + (b ? STEP_BYTE : STEP_WORD))
    `CHK(addr_error_pulse, ~b & a[0])
    if (stb[0]) `CHK(wr_data_out[7:0], d[7:0])
    if (stb[1]) `CHK(wr_data_out[15:8], b ? d[7:0] : d[15:8])
    if (~b & a[0]) `CHK(addr_error_is_write, 1'b1)
    @(posedge clk);
    #1;
    `CHK(addr_error_pulse, 1'b0)
  endtask : wr

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_prog();
    @(posedge clk);
    #1;
    `CHK(prog_addr, PROG_RESET_ADDR)
    `CHK(prog_in_vectors, 1'b1)
    @(posedge clk);
    pc_advance <= 1'b1;
    repeat (3) @(posedge clk);
    pc_advance <= 1'b0;
    pc_retreat <= 1'b1;
    @(posedge clk);
    pc_retreat <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(prog_addr, 24'h000004)
    `CHK(prog_upper_word, 1'b0)
    @(posedge clk);
    pc_load <= 1'b1;
    pc_load_value <= 23'h000200;
    @(posedge clk);
    pc_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(prog_addr, PROG_USER_START)
    `CHK(prog_in_vectors, 1'b0)
    `CHK(prog_access_ok, 1'b1)
    @(posedge clk);
    tbl_req <= '{1'b1, 1'b1, 8'h80, 16'h0013};
    @(posedge clk);
    tbl_req <= '0;
    #1;
    `CHK(prog_addr, 24'h800013)
    `CHK(prog_upper_word, 1'b1)
    `CHK(prog_access_ok, 1'b1)
    @(posedge clk);
    tbl_req <= '{1'b1, 1'b0, 8'h00, 16'h0000};
    psv_enable <= 1'b1;
    visibility_page_reg <= 8'h12;
    rd_req <= '{1'b1, 1'b0, 16'h8010};
    @(posedge clk);
    tbl_req <= '0;
    rd_req <= '0;
    psv_enable <= 1'b0;
    #1;
    `CHK(prog_addr, {1'b0, 8'h12, 15'h0010})
    $display("program space test done");
  endtask : t_prog

  task automatic t_data();
    wr(16'h0802, 1'b0, 16'h1234, 2'b11);
    wr(16'h0803, 1'b1, 16'h00ab, 2'b10);
    rd(16'h0802, 1'b0, 16'hab34);
    rd(16'h0803, 1'b1, 16'h00ab);
    rd(16'h0802, 1'b1, 16'h0034);
    wr(16'h0805, 1'b0, 16'hdead, 2'b00);
    rd(16'h0804, 1'b0, 16'h1002);
    rd(16'h0807, 1'b0, 16'h0000);
    `CHK(addr_error_is_write, 1'b0)
    rd(16'h0020, 1'b0, 16'h1010);
    rd(16'h0050, 1'b0, ZERO_WORD);
    rd(16'h7ffe, 1'b0, ZERO_WORD);
    rd(16'h7ffd, 1'b1, ZERO_WORD);
    @(posedge clk);
    near_direct <= 1'b1;
    near_field <= 13'h0804;
    rd_req <= '{1'b1, 1'b0, 16'h0000};
    @(posedge clk);
    near_direct <= 1'b0;
    rd_req <= '0;
    #1;
    `CHK(rd_word_addr, 16'h0804)
    $display("data space test done");
  endtask : t_data

  task automatic t_wreg();
    @(posedge clk);
    wreg_wr <= 1'b1;
    wreg_idx <= 4'h3;
    wreg_data <= 16'h1234;
    @(posedge clk);
    wreg_byte <= 1'b1;
    wreg_data <= 16'h55ab;
    @(posedge clk);
    wreg_byte <= 1'b0;
    wreg_idx <= 4'h4;
    ext_op <= MSD_EXT_SIGN;
    wreg_data <= 16'h0080;
    @(posedge clk);
    wreg_idx <= 4'h5;
    ext_op <= MSD_EXT_ZERO;
    wreg_data <= 16'hff7f;
    @(posedge clk);
    wreg_wr <= 1'b0;
    ext_op <= MSD_EXT_NONE;
    #1;
    `CHK(wreg_out[3], 16'h12ab)
    `CHK(wreg_out[4], 16'hff80)
    `CHK(wreg_out[5], 16'h007f)
    $display("register update test done");
  endtask : t_wreg

  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_prog();
    t_data();
    t_wreg();
    conclude();
  end

  // whole run needs about 65 cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule : msd_memory_space_address_decode_tb
`default_nettype wire
